// ### core/ctg_pkg.sv
// package: constants and carrier types for the clock timing generator
package ctg_pkg;
	localparam int PRE_STAGES     = 3;
	localparam int DIV_STAGES     = 21;
	localparam int DIV1_SEL_BIT   = 5;
	localparam int DIV7_SEL_BIT   = 4;
	localparam int STAGE7_IDX     = 6;
	localparam int STATES_PER_MC  = 4;
	localparam logic [2:0]  PRE_RESET = 3'h0;
	localparam logic [20:0] DIV_RESET = 21'h00000;
	localparam logic [1:0]  MC_RESET  = 2'h0;
	localparam logic [1:0]  MC_LAST   = 2'h3;
	// tap positions are a free choice; peripherals only need fixed rates
	localparam int TAP_TIMEBASE   = 20;
	localparam int TAP_WATCHDOG   = 19;
	localparam int TAP_TIMER      = 6;
	localparam int TAP_SERIAL     = 2;
	localparam int TAP_DISPLAY    = 8;
	localparam int TAP_PULSE      = 12;
	localparam int TAP_WARMUP     = 13;
	localparam int TAP_RESET_REL  = 18;

	typedef enum logic [2:0] {
		CTG_SINGLE_RUN  = 3'h0,
		CTG_SINGLE_IDLE = 3'h1,
		CTG_DUAL_RUN    = 3'h2,
		CTG_DUAL_IDLE   = 3'h3,
		CTG_SLOW        = 3'h4,
		CTG_SLEEP       = 3'h5,
		CTG_STOP        = 3'h6
	} ctg_mode_type;

	typedef struct packed {
		logic       divInSelect;
		logic       stage7Select;
		logic       systemClockSelect;
		ctg_mode_type mode;
	} ctg_ctrl_type;

	typedef struct packed {
		logic [20:0] divStage;
		logic        mainClkEn;
		logic [1:0]  machineState;
		logic        machineCycleEn;
	} ctg_clk_type;
endpackage

// ### core/ctg_timing_gen.sv
// clock timing generator: prescaler, 21-stage divider, main clock and machine cycles
`timescale 1ns/1ps
// Function
// [R1] three prescaler stages on high clock, twenty-one divider stages, main clock, cycle count
// [R2] divider first stage takes high clock over 4 or over 8 by select bit 5
// [R3] over-8 input keeps divider rates when the high clock doubles
// [R4] software sets divider input select before peripherals start, never changes it
// [R5] prescaler and divider clear on reset and on stop entry or release
// [R6] single-clock modes: stage seven input is high clock over 2^8 or 2^9
// [R7] dual fast modes: stage seven takes low clock when its source select is set; the code also needs systemClockSelect clear
// [R8] slow and sleep: stage seven on low clock, stages one to six stopped
// [R9] software never sets stage seven source select in single-clock mode
// [R10] divider taps feed timebase, watchdog, timers, serial, display, pulse, warm-up, reset
// [R11] every divider stage halves its input frequency
// [R12] machine cycle is four states of one main clock each
// [R13] dual mode main clock: high clock in fast modes, low clock in slow and sleep
// [R14] after reset: single-clock run, low oscillator disabled until software enables it
module ctg_timing_gen (
	input  wire logic                 clock,
	input  wire logic                 srst,
	input  wire logic                 highClkEn,
	input  wire logic                 lowClkEn,
	input  wire logic [7:0]           clockGearControl,
	input  wire logic [7:0]           timebaseControl,
	input  wire logic                 systemClockSelect,
	input  wire ctg_pkg::ctg_mode_type mode,
	output logic                      lowOscEnable,
	input  wire logic                 lowOscEnableReq,
	output ctg_pkg::ctg_clk_type      clkOut,
	output logic [20:0]               dividerStageEn,
	output logic                      timebaseSrc,
	output logic                      watchdogSrc,
	output logic                      timerSrc,
	output logic                      serialSrc,
	output logic                      displaySrc,
	output logic                      dividerPulseOutput,
	output logic                      warmupSrc,
	output logic                      resetReleaseSrc
);
	logic                 stop_ff;
	logic                 stopEdge;
	logic                 clear;
	logic [2:0]           pre_ff;
	logic [2:0]           preEn;
	logic                 divInSelect;
	logic                 stage7Select;
	logic                 slowMode;
	logic                 singleMode;
	logic                 div1En;
	logic [5:0]           lowStage;
	logic [5:0]           lowStageEn;
	logic                 div7En;
	logic [14:0]          highStage;
	logic [14:0]          highStageEn;
	logic                 mainClkEn;
	logic [1:0]           mcState_ff;
	logic                 lowOsc_ff;
	logic [20:0]          divOut_ff;
	logic [20:0]          divStage;
	logic                 stopMode;
	logic [1:0]           nxt_mcState;
	ctg_pkg::ctg_ctrl_type ctrl;

	// mode decodes shared by gating, stage seven source and the stop clear
	function automatic logic is_stop(input ctg_pkg::ctg_mode_type m);
		return m == ctg_pkg::CTG_STOP;
	endfunction

	function automatic logic is_slow(input ctg_pkg::ctg_mode_type m);
		return (m == ctg_pkg::CTG_SLOW) || (m == ctg_pkg::CTG_SLEEP);
	endfunction

	function automatic logic is_single(input ctg_pkg::ctg_mode_type m);
		return (m == ctg_pkg::CTG_SINGLE_RUN) || (m == ctg_pkg::CTG_SINGLE_IDLE);
	endfunction

	// a stage falls when its enable arrives while it is high
	function automatic logic fall_en(input logic en, input logic level);
		return en & level;
	endfunction

	// control image gathered once so every consumer sees one decode
	// input select is not guarded; changing it mid-run skews every tap while stage seven follows stage six
	always_comb begin
		ctrl.divInSelect       = clockGearControl[ctg_pkg::DIV1_SEL_BIT]; // R2
		ctrl.stage7Select      = timebaseControl[ctg_pkg::DIV7_SEL_BIT]; // R7
		ctrl.systemClockSelect = systemClockSelect;
		ctrl.mode              = mode;
	end
	assign divInSelect  = ctrl.divInSelect;
	assign stage7Select = ctrl.stage7Select;
	assign stopMode     = is_stop(ctrl.mode);
	assign slowMode     = is_slow(ctrl.mode);
	assign singleMode   = is_single(ctrl.mode);

	// clear on both edges of stop, so entry and release each restart the chain
	always_ff @(posedge clock) begin
		if (srst) begin
			stop_ff <= 1'b0;
		end else begin
			stop_ff <= stopMode;
		end
	end
	assign stopEdge = stop_ff ^ stopMode;
	assign clear    = srst | stopEdge | stopMode; // R5

	// prescaler: three toggle stages counted on high clock enables
	always_comb begin
		preEn[0] = highClkEn & ~slowMode;
		preEn[1] = fall_en(preEn[0], pre_ff[0]);
		preEn[2] = fall_en(preEn[1], pre_ff[1]);
	end
	always_ff @(posedge clock) begin
		if (clear) begin
			pre_ff <= ctg_pkg::PRE_RESET; // R5
		end else begin
			pre_ff <= pre_ff ^ preEn; // R1
		end
	end

	// falling edge of stage 2 or 3 gives high/4 or high/8
	assign div1En = divInSelect ? fall_en(preEn[2], pre_ff[2]) : fall_en(preEn[1], pre_ff[1]); // R2 R3

	// first six stages gated off in slow and sleep since no high clock runs
	ctg_toggle_chain #(.N(6)) u_low (
		.clock   (clock),
		.clear   (clear),
		.inEn    (div1En & ~slowMode), // R8
		.stage   (lowStage),
		.stageEn (lowStageEn)
	); // R11

	// stage seven source; select ignored in single mode and when systemClockSelect is set
	always_comb begin
		if (slowMode) begin
			div7En = lowClkEn; // R8
		end else if (!singleMode && !ctrl.systemClockSelect && stage7Select) begin
			div7En = lowClkEn; // R7
		end else begin
			div7En = fall_en(lowStageEn[5], lowStage[5]); // R6
		end
	end

	ctg_toggle_chain #(.N(15)) u_high (
		.clock   (clock),
		.clear   (clear),
		.inEn    (div7En),
		.stage   (highStage),
		.stageEn (highStageEn)
	); // R11

	assign divStage = {highStage, lowStage};

	// main clock source per mode; stop leaves the machine cycle frozen
	always_comb begin
		case (ctrl.mode)
			ctg_pkg::CTG_SINGLE_RUN, ctg_pkg::CTG_SINGLE_IDLE: begin
				mainClkEn = highClkEn;
			end
			ctg_pkg::CTG_DUAL_RUN, ctg_pkg::CTG_DUAL_IDLE: begin
				mainClkEn = highClkEn; // R13
			end
			ctg_pkg::CTG_SLOW, ctg_pkg::CTG_SLEEP: begin
				mainClkEn = lowClkEn; // R13
			end
			default: begin
				mainClkEn = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			mcState_ff <= ctg_pkg::MC_RESET;
		end else if (mainClkEn) begin
			mcState_ff <= nxt_mcState; // R12
		end
	end

	// four states per machine cycle, then wrap to the first
	always_comb begin
		if (mcState_ff == ctg_pkg::MC_LAST) begin
			nxt_mcState = ctg_pkg::MC_RESET;
		end else begin
			nxt_mcState = mcState_ff + 2'h1;
		end
	end

	// low oscillator off after reset until requested
	always_ff @(posedge clock) begin
		if (srst) begin
			lowOsc_ff <= 1'b0; // R14
		end else begin
			lowOsc_ff <= lowOscEnableReq;
		end
	end
	assign lowOscEnable = lowOsc_ff;

	// registered taps; fixed positions are an arbitrary but stable choice
	always_ff @(posedge clock) begin
		if (srst) begin
			divOut_ff <= ctg_pkg::DIV_RESET;
		end else begin
			divOut_ff <= divStage;
		end
	end
	assign dividerStageEn     = {highStageEn, lowStageEn};
	assign timebaseSrc        = divOut_ff[ctg_pkg::TAP_TIMEBASE];  // R10
	assign watchdogSrc        = divOut_ff[ctg_pkg::TAP_WATCHDOG];  // R10
	assign timerSrc           = divOut_ff[ctg_pkg::TAP_TIMER];     // R10
	assign serialSrc          = divOut_ff[ctg_pkg::TAP_SERIAL];    // R10
	assign displaySrc         = divOut_ff[ctg_pkg::TAP_DISPLAY];   // R10
	assign dividerPulseOutput = divOut_ff[ctg_pkg::TAP_PULSE];     // R10
	assign warmupSrc          = divOut_ff[ctg_pkg::TAP_WARMUP];    // R10
	assign resetReleaseSrc    = divOut_ff[ctg_pkg::TAP_RESET_REL]; // R10

	always_comb begin
		clkOut.divStage       = divOut_ff;
		clkOut.mainClkEn      = mainClkEn;
		clkOut.machineState   = mcState_ff;
		clkOut.machineCycleEn = mainClkEn & (mcState_ff == ctg_pkg::MC_LAST); // R12
	end
endmodule

// ### core/ctg_toggle_chain.sv
// ripple of toggle stages driven by one-cycle enables
`timescale 1ns/1ps
module ctg_toggle_chain #(
	parameter int N = 6
) (
	input  wire logic         clock,
	input  wire logic         clear,
	input  wire logic         inEn,
	output logic [N-1:0]      stage,
	output logic [N-1:0]      stageEn
);
	logic [N-1:0] stage_ff;

	// stage k toggles when stage k-1 falls; enable marks that moment
	always_comb begin
		stageEn[0] = inEn;
		for (int k = 1; k < N; k++) begin
			stageEn[k] = stageEn[k-1] & stage_ff[k-1];
		end
	end

	always_ff @(posedge clock) begin
		if (clear) begin
			stage_ff <= '0;
		end else begin
			stage_ff <= stage_ff ^ stageEn;
		end
	end

	assign stage = stage_ff;
endmodule

// ### tb/ctg_timing_gen_properties.sv
// checker: port properties of the timing generator
`timescale 1ns/1ps
module ctg_timing_gen_properties (
	input wire logic                  clock,
	input wire logic                  srst,
	input wire logic                  highClkEn,
	input wire logic                  lowClkEn,
	input wire logic [7:0]            timebaseControl,
	input wire logic                  systemClockSelect,
	input wire ctg_pkg::ctg_mode_type mode,
	input wire logic                  lowOscEnable,
	input wire ctg_pkg::ctg_clk_type  clkOut,
	input wire logic [20:0]           dividerStageEn
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	wire slowMode = (mode == ctg_pkg::CTG_SLOW) || (mode == ctg_pkg::CTG_SLEEP);
	wire dualFast = (mode == ctg_pkg::CTG_DUAL_RUN) || (mode == ctg_pkg::CTG_DUAL_IDLE);
	wire stopMode = (mode == ctg_pkg::CTG_STOP);
	// taps load zero on the first reset edge; the clear is judged after two reset cycles
	property p_reset; disable iff (1'b0) srst ##1 srst |=> clkOut.divStage == 21'h00000
		&& clkOut.machineState == 2'h0 && !lowOscEnable; endproperty
	a_reset: assert property (p_reset) else $error("reset clear");
	property p_stop; mode == ctg_pkg::CTG_STOP ##1 mode == ctg_pkg::CTG_STOP
		|=> clkOut.divStage == 21'h00000; endproperty
	a_stop: assert property (p_stop) else $error("stop clear");
	property p_slow; slowMode |-> dividerStageEn[5:0] == 6'h00; endproperty
	a_slow: assert property (p_slow) else $error("low stages run");
	property p_slowfs; slowMode && dividerStageEn[6] |-> lowClkEn; endproperty
	a_slowfs: assert property (p_slowfs) else $error("stage7 slow source");
	property p_dual; dualFast && timebaseControl[4] && !systemClockSelect && dividerStageEn[6]
		|-> lowClkEn; endproperty
	a_dual: assert property (p_dual) else $error("stage7 dual source");
	property p_single; mode <= ctg_pkg::CTG_SINGLE_IDLE && dividerStageEn[6]
		|-> dividerStageEn[5]; endproperty
	a_single: assert property (p_single) else $error("stage7 single source");
	property p_space; dividerStageEn[0] |=> !dividerStageEn[0] [*3]; endproperty
	a_space: assert property (p_space) else $error("stage1 spacing");
	property p_mc; clkOut.machineCycleEn |-> clkOut.mainClkEn
		&& clkOut.machineState == ctg_pkg::MC_LAST; endproperty
	a_mc: assert property (p_mc) else $error("machine cycle");
	property p_mcwrap; clkOut.machineCycleEn |=> clkOut.machineState == 2'h0; endproperty
	a_mcwrap: assert property (p_mcwrap) else $error("machine cycle wrap");
	property p_mcstep; clkOut.mainClkEn && !clkOut.machineCycleEn
		|=> clkOut.machineState == $past(clkOut.machineState) + 2'h1; endproperty
	a_mcstep: assert property (p_mcstep) else $error("machine state step");
	property p_mainfast; !slowMode && !stopMode |-> clkOut.mainClkEn == highClkEn; endproperty
	a_mainfast: assert property (p_mainfast) else $error("main clock fast source");
	property p_mainslow; slowMode |-> clkOut.mainClkEn == lowClkEn; endproperty
	a_mainslow: assert property (p_mainslow) else $error("main clock slow source");
	property p_mainstop; stopMode |-> !clkOut.mainClkEn; endproperty
	a_mainstop: assert property (p_mainstop) else $error("main clock in stop");
endmodule

// ### tb/tb_clock_timing_generator.sv
// testbench: random tick streams through every mode and input select
`timescale 1ns/1ps
module tb_clock_timing_generator;
	logic                  clock = 0, srst = 1, highClkEn = 0, lowClkEn = 0;
	logic                  systemClockSelect = 0, lowOscEnableReq = 0, lowOscEnable;
	logic [7:0]            clockGearControl = 8'h00, timebaseControl = 8'h00;
	ctg_pkg::ctg_mode_type mode = ctg_pkg::CTG_SINGLE_RUN;
	ctg_pkg::ctg_clk_type  clkOut;
	logic [20:0]           dividerStageEn;
	logic                  timebaseSrc, watchdogSrc, timerSrc, serialSrc, displaySrc;
	logic                  dividerPulseOutput, warmupSrc, resetReleaseSrc;
	int                    n_errors = 0, comparisons = 0, h, l, e0, e6, mc, mce, s7;
	initial forever #12.5 clock = ~clock;
	ctg_timing_gen dut_u (
		.clock              (clock),
		.srst               (srst),
		.highClkEn          (highClkEn),
		.lowClkEn           (lowClkEn),
		.clockGearControl   (clockGearControl),
		.timebaseControl    (timebaseControl),
		.systemClockSelect  (systemClockSelect),
		.mode               (mode),
		.lowOscEnable       (lowOscEnable),
		.lowOscEnableReq    (lowOscEnableReq),
		.clkOut             (clkOut),
		.dividerStageEn     (dividerStageEn),
		.timebaseSrc        (timebaseSrc),
		.watchdogSrc        (watchdogSrc),
		.timerSrc           (timerSrc),
		.serialSrc          (serialSrc),
		.displaySrc         (displaySrc),
		.dividerPulseOutput (dividerPulseOutput),
		.warmupSrc          (warmupSrc),
		.resetReleaseSrc    (resetReleaseSrc)
	);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task print_verdict;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	function automatic int exp6(int m, int s, int t, int f);
		if (m == 6) return 0;
		if (m >= 4 || (m >= 2 && s7 == 1)) return f;
		return t / (s ? 512 : 256);
	endfunction
	function automatic int exp_stages(int m, int s, int t, int f);
		int n;
		n = t / (s ? 8 : 4);
		if (m == 6) return 0;
		if (m >= 4) return (f % 32768) << 6;
		if (m >= 2 && s7 == 1) return ((f % 32768) << 6) | (n % 64);
		return n % 2097152;
	endfunction
	task automatic run(input int m, input int s);
		@(negedge clock);
		srst = 1;
		mode = ctg_pkg::ctg_mode_type'(m);
		s7 = (m == 2 || m == 3) ? $urandom % 2 : 0;
		clockGearControl = 8'(s << 5);
		timebaseControl = 8'(s7 << 4);
		systemClockSelect = (m == 4 || m == 5);
		lowOscEnableReq = 1'($urandom % 2);
		repeat (2) @(negedge clock);
		check(lowOscEnable, 0, "osc in reset");
		check(clkOut.machineState, ctg_pkg::MC_RESET, "state in reset");
		srst = 0;
		{h, l, e0, e6, mc, mce} = '0;
		repeat (1100) begin
			highClkEn = 1'($urandom % 2);
			lowClkEn = ($urandom % 8) == 0;
			#1;
			h += highClkEn;
			l += lowClkEn;
			e0 += dividerStageEn[0];
			e6 += dividerStageEn[6];
			mc += clkOut.mainClkEn;
			mce += clkOut.machineCycleEn;
			@(negedge clock);
		end
		highClkEn = 0;
		lowClkEn = 0;
		repeat (2) @(negedge clock);
		check(e0, (m >= 4) ? 0 : h / (s ? 8 : 4), "stage1 count");
		check(e6, exp6(m, s, h, l), "stage7 count");
		check(mc, (m == 6) ? 0 : ((m >= 4) ? l : h), "main clock count");
		check(mce, ((m == 6) ? 0 : ((m >= 4) ? l : h)) / 4, "cycle count");
		check(clkOut.divStage, exp_stages(m, s, h, l), "stage levels");
		check(lowOscEnable, lowOscEnableReq, "osc enable");
		check({timebaseSrc, watchdogSrc, timerSrc, serialSrc, displaySrc, dividerPulseOutput,
			warmupSrc, resetReleaseSrc}, {clkOut.divStage[20], clkOut.divStage[19],
			clkOut.divStage[6], clkOut.divStage[2], clkOut.divStage[8], clkOut.divStage[12],
			clkOut.divStage[13], clkOut.divStage[18]}, "taps");
		if (m == 6) check(clkOut.divStage, 0, "stop stages");
	endtask
	initial begin
		void'($urandom(32'h8E5D));
		repeat (12) @(negedge clock);
		for (int m = 0; m < 7; m++) for (int s = 0; s < 2; s++) run(m, s);
		print_verdict;
	end
endmodule
bind ctg_timing_gen ctg_timing_gen_properties chk_u (
	.clock             (clock),
	.srst              (srst),
	.highClkEn         (highClkEn),
	.lowClkEn          (lowClkEn),
	.timebaseControl   (timebaseControl),
	.systemClockSelect (systemClockSelect),
	.mode              (mode),
	.lowOscEnable      (lowOscEnable),
	.clkOut            (clkOut),
	.dividerStageEn    (dividerStageEn)
);
